// ---- rtl/pixel_out_pkg.sv ----
// Shared constants, register map and types of the parallel RGB pixel output stage
package pixel_out_pkg;

    // ==========================================================
    // Colour and bus geometry
    localparam int COMP_W = 8;
    localparam int BUS_W = 24;
    localparam int COMP_MSB = 7;
    localparam int C5_LSB = 3;
    localparam int C6_LSB = 2;
    localparam int PAD16_W = 8;
    localparam int PAD18_W = 6;
    localparam logic [23:0] MASK_ALIGN16 = 24'hf8fcf8;
    localparam logic [23:0] MASK_ALIGN18 = 24'hfcfcfc;

    typedef struct packed {
        logic [COMP_W-1:0] red;
        logic [COMP_W-1:0] green;
        logic [COMP_W-1:0] blue;
    } pixel_type;

    // Encoded as 0..4 in the control register
    typedef enum logic [2:0] {
        FMT_FULL24,
        FMT_PACK16,
        FMT_PACK18,
        FMT_ALIGN16,
        FMT_ALIGN18
    } format_type;

    typedef struct packed {
        logic touch_run;
        logic panel_on;
        logic backlight_on;
        logic route_serial;
        format_type format;
    } ctrl_type;

    // ==========================================================
    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] DUTY_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] MASK_OFFSET = 8'h0c;
    localparam logic [7:0] LEVEL_OFFSET = 8'h10;
    localparam int CTRL_W = 7;
    localparam ctrl_type CTRL_RESET = '0;
    localparam logic [7:0] DUTY_RESET = 8'h00;

    // Event bits of status and mask
    localparam int EV_W = 2;
    localparam int EV_TOUCH = 0;
    localparam int EV_LINE_END = 1;
    localparam logic [1:0] EV_RESET = 2'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // PWM tick divider: 125 MHz / 50 / 256 steps, close to 10 kHz
    localparam logic [15:0] PWM_DIV = 16'h0031;

endpackage

// ---- rtl/edge_sync.sv ----
// Two-flop synchroniser with rising-edge detection for an outside signal
module edge_sync (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Outside signal
    input wire logic async_in,
    // Synchronised results
    output logic level,
    output logic rise
);

    logic meta;
    logic stage;
    logic prev;

    // ==========================================================
    // Synchroniser chain, first flop read only by the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= 1'b0;
            stage <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= async_in;
            stage <= meta;
            prev <= stage;
        end
    end

    // Level and edge taken from the settled stages
    assign level = stage;
    assign rise = stage & ~prev;

endmodule

// ---- rtl/backlight_pwm.sv ----
// Backlight PWM generator with an 8-bit duty cycle
module backlight_pwm (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Duty setting, 0 is off, 255 nearly full
    input wire logic [7:0] duty,
    // PWM output
    output logic pwm_out
);

    logic [15:0] div_count;
    logic tick;
    logic [7:0] phase;

    // ==========================================================
    // Divider producing one-cycle step pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_count <= '0;
            tick <= 1'b0;
        end else if (div_count == pixel_out_pkg::PWM_DIV) begin
            div_count <= '0;
            tick <= 1'b1;
        end else begin
            div_count <= div_count + 16'h0001;
            tick <= 1'b0;
        end
    end

    // Phase counter and comparator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= '0;
            pwm_out <= 1'b0;
        end else begin
            if (tick) begin
                phase <= phase + 8'h01;
            end
            pwm_out <= (phase < duty);
        end
    end

endmodule

// ---- rtl/rgb_pixel_out.sv ----
// Parallel RGB pixel output stage with side-band panel controls and AXI4-Lite registers
// Operation
// R1: Full 24-bit mode puts blue 0-7 on lines 0-7, green 0 on line 8.
// R2: Packed 16-bit: blue 0-4 on lines 0-4, green 0-3 on lines 5-8.
// R3: Packed 18-bit: blue 0-5 on lines 0-5, green 0-2 on lines 6-8.
// R4: Aligned narrow modes keep each colour at its top bits, low lines zero.
// R5: Narrow panels ignore the low bits of each colour on the full bus.
// R6: Reset selects the full 24-bit bus width by default.
// R7: Only one output stream at a time; parallel and serial carry identical data.
// R8: Backlight PWM output duty cycle sets contrast.
// R9: Backlight supply enable output, high switches supply on.
// R10: Panel supply enable output, high switches supply on.
// R11: Touch controller reset output active low, low holds it in reset.
// R12: Touch controller signals events on an input the device samples.
// R13: One pixel per clock is sustained, enough for 1920x1080 at 60 fps; here at most one pixel per two aclk cycles (62.5 MHz at 125 MHz).
// R14: Full 24-bit mode puts green on lines 8-15 and red on 16-23.
// R15: Lines update on pixel clock edges; enable high only for active pixels.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
module rgb_pixel_out (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Pixel source, same clock
    input wire pixel_out_pkg::pixel_type pixel_in,
    input wire logic pixel_active_in,
    // Link pixel clock, outside domain
    input wire logic pixel_clk_in,
    // Parallel panel bus
    output logic [23:0] pixel_data_line,
    output logic pixel_de_out,
    output logic pixel_clk_out,
    // Serial transmitter feed
    output logic [23:0] serial_pixel_out,
    output logic serial_valid_out,
    // Panel side-band
    output logic backlight_duty_out,
    output logic backlight_supply_on,
    output logic panel_supply_on,
    output logic touch_reset_n,
    input wire logic touch_event_in,
    // Interrupt
    output logic irq
);

    pixel_out_pkg::ctrl_type ctrl;
    logic [7:0] duty;
    logic [pixel_out_pkg::EV_W-1:0] status;
    logic [pixel_out_pkg::EV_W-1:0] mask;
    logic [pixel_out_pkg::EV_W-1:0] next_set;
    logic [pixel_out_pkg::EV_W-1:0] next_clr;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_got;
    logic w_got;
    logic do_write;
    logic pclk_level;
    logic pix_tick;
    logic touch_level;
    logic touch_rise;
    logic [23:0] packed_word;

    // ==========================================================
    // Synchronisers for pixel clock and touch event
    edge_sync pclk_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pixel_clk_in),
        .level(pclk_level),
        .rise(pix_tick)
    );

    // R12: touch event sampled
    edge_sync touch_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(touch_event_in),
        .level(touch_level),
        .rise(touch_rise)
    );

    // R8: PWM from duty register
    backlight_pwm pwm (
        .aclk(aclk),
        .aresetn(aresetn),
        .duty(duty),
        .pwm_out(backlight_duty_out)
    );

    // ==========================================================
    // Colour packing per format
    function automatic logic [23:0] pack_pixel(input pixel_out_pkg::pixel_type p,
                                               input pixel_out_pkg::format_type f);
        logic [23:0] word;
        word = p;
        unique case (f)
            pixel_out_pkg::FMT_FULL24: word = p;
            pixel_out_pkg::FMT_PACK16: word = {{pixel_out_pkg::PAD16_W{1'b0}},
                p.red[pixel_out_pkg::COMP_MSB:pixel_out_pkg::C5_LSB],
                p.green[pixel_out_pkg::COMP_MSB:pixel_out_pkg::C6_LSB],
                p.blue[pixel_out_pkg::COMP_MSB:pixel_out_pkg::C5_LSB]};
            pixel_out_pkg::FMT_PACK18: word = {{pixel_out_pkg::PAD18_W{1'b0}},
                p.red[pixel_out_pkg::COMP_MSB:pixel_out_pkg::C6_LSB],
                p.green[pixel_out_pkg::COMP_MSB:pixel_out_pkg::C6_LSB],
                p.blue[pixel_out_pkg::COMP_MSB:pixel_out_pkg::C6_LSB]};
            pixel_out_pkg::FMT_ALIGN16: word = p & pixel_out_pkg::MASK_ALIGN16;
            pixel_out_pkg::FMT_ALIGN18: word = p & pixel_out_pkg::MASK_ALIGN18;
            default: word = p;
        endcase
        return word;
    endfunction

    // R1 R2 R3: lane mapping per mode
    // R4 R14: aligned and full packing
    assign packed_word = pack_pixel(pixel_in, ctrl.format);

    // ==========================================================
    // R13 R15: one pixel per tick, lines move on ticks only
    // R7: one route enabled, same word on both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pixel_data_line <= '0;
            pixel_de_out <= 1'b0;
            serial_pixel_out <= '0;
            serial_valid_out <= 1'b0;
        end else if (pix_tick) begin
            pixel_data_line <= ctrl.route_serial ? pixel_data_line : packed_word;
            pixel_de_out <= pixel_active_in & ~ctrl.route_serial;
            serial_pixel_out <= ctrl.route_serial ? packed_word : serial_pixel_out;
            serial_valid_out <= pixel_active_in & ctrl.route_serial;
        end else begin
            serial_valid_out <= 1'b0;
        end
    end

    // Pixel clock forwarded to the panel, aligned with data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pixel_clk_out <= 1'b0;
        end else begin
            pixel_clk_out <= pclk_level;
        end
    end

    // ==========================================================
    // R9 R10 R11: side-band drives from control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            backlight_supply_on <= 1'b0;
            panel_supply_on <= 1'b0;
            touch_reset_n <= 1'b0;
        end else begin
            backlight_supply_on <= ctrl.backlight_on;
            panel_supply_on <= ctrl.panel_on;
            touch_reset_n <= ctrl.touch_run;
        end
    end

    // ==========================================================
    // AXI write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_got <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_got <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
            end
            if (bvalid && bready) begin
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    assign do_write = aw_got && w_got && !bvalid;

    // Write response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= pixel_out_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= (aw_addr > pixel_out_pkg::LEVEL_OFFSET) ? pixel_out_pkg::RESP_SLVERR
                                                             : pixel_out_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // R6: reset keeps full 24-bit format
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= pixel_out_pkg::CTRL_RESET;
            duty <= pixel_out_pkg::DUTY_RESET;
            mask <= pixel_out_pkg::EV_RESET;
        end else if (do_write && w_strb[0]) begin
            unique case (aw_addr)
                pixel_out_pkg::CTRL_OFFSET: ctrl <= w_data[pixel_out_pkg::CTRL_W-1:0];
                pixel_out_pkg::DUTY_OFFSET: duty <= w_data[7:0];
                pixel_out_pkg::MASK_OFFSET: mask <= w_data[pixel_out_pkg::EV_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Sticky events, set wins over write-one clear
    always_comb begin
        next_set = '0;
        next_set[pixel_out_pkg::EV_TOUCH] = touch_rise;
        next_set[pixel_out_pkg::EV_LINE_END] = pix_tick & pixel_de_out & ~pixel_active_in;
        next_clr = '0;
        if (do_write && w_strb[0] && aw_addr == pixel_out_pkg::STATUS_OFFSET) begin
            next_clr = w_data[pixel_out_pkg::EV_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= pixel_out_pkg::EV_RESET;
            irq <= 1'b0;
        end else begin
            status <= (status & ~next_clr) | next_set;
            irq <= |(status & mask);
        end
    end

    // ==========================================================
    // AXI read, answer one cycle after address taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= pixel_out_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= pixel_out_pkg::RESP_OKAY;
            unique case (araddr)
                pixel_out_pkg::CTRL_OFFSET: rdata <= 32'(ctrl);
                pixel_out_pkg::DUTY_OFFSET: rdata <= 32'(duty);
                pixel_out_pkg::STATUS_OFFSET: rdata <= 32'(status);
                pixel_out_pkg::MASK_OFFSET: rdata <= 32'(mask);
                pixel_out_pkg::LEVEL_OFFSET: rdata <= 32'({touch_level, pclk_level});
                default: begin
                    rdata <= '0;
                    rresp <= pixel_out_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    // R1 R14: full mode lane order
    a_full_pack: assert property (@(posedge aclk) disable iff (!aresetn) // R1 R14
        pix_tick && !ctrl.route_serial && ctrl.format == pixel_out_pkg::FMT_FULL24
        |=> pixel_data_line == $past(pixel_in)) else $error("full 24-bit packing wrong");
    // R2: packed 16-bit lanes
    a_pack16_lanes: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        pix_tick && !ctrl.route_serial && ctrl.format == pixel_out_pkg::FMT_PACK16
        |=> pixel_data_line[4:0] == $past(pixel_in.blue[7:3])
            && pixel_data_line[8:5] == $past(pixel_in.green[5:2])) else $error("16-bit packing wrong");
    // R3: packed 18-bit lanes
    a_pack18_lanes: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        pix_tick && !ctrl.route_serial && ctrl.format == pixel_out_pkg::FMT_PACK18
        |=> pixel_data_line[5:0] == $past(pixel_in.blue[7:2])
            && pixel_data_line[8:6] == $past(pixel_in.green[4:2])) else $error("18-bit packing wrong");
    // R4: aligned 16-bit mode zeroes the low blue lanes
    a_align_low: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        pix_tick && !ctrl.route_serial && ctrl.format == pixel_out_pkg::FMT_ALIGN16
        |=> pixel_data_line[2:0] == 3'h0 && pixel_data_line[7:3] == $past(pixel_in.blue[7:3]))
        else $error("aligned 16-bit lanes wrong");
    // R6: full width after reset
    a_reset_full: assert property (@(posedge aclk) // R6
        !aresetn |=> ctrl.format == pixel_out_pkg::FMT_FULL24) else $error("reset format not 24-bit");
    // R7: never two streams
    a_single_route: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        !(pixel_de_out && serial_valid_out)) else $error("both routes active");
    // R8: zero duty keeps backlight PWM low
    a_pwm_off: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        duty == 8'h00 [*2] |-> !backlight_duty_out) else $error("pwm high at zero duty");
    // R9 R10: supplies follow control one cycle later
    a_supply_follow: assert property (@(posedge aclk) disable iff (!aresetn) // R9 R10
        ##1 backlight_supply_on == $past(ctrl.backlight_on) && panel_supply_on == $past(ctrl.panel_on))
        else $error("supply enable mismatch");
    // R11: touch held in reset while not released
    a_touch_reset: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        !ctrl.touch_run [*2] |-> !touch_reset_n) else $error("touch reset released early");
    // R13 R15: data holds between pixel edges
    a_hold_idle: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        !pix_tick |=> $stable(pixel_data_line) && $stable(pixel_de_out)) else $error("data moved off edge");

    c_full_frame: cover property (@(posedge aclk) disable iff (!aresetn) pixel_de_out ##1 !pixel_de_out);
    c_serial_route: cover property (@(posedge aclk) disable iff (!aresetn) serial_valid_out);
    c_touch_irq: cover property (@(posedge aclk) disable iff (!aresetn) touch_rise ##[1:4] irq);
    c_write_read: cover property (@(posedge aclk) disable iff (!aresetn) bvalid ##[1:8] rvalid);

endmodule

// ---- test/panel_touch_model.sv ----
// Behavioural LCD panel with touch controller on the far side of the pixel bus
module panel_touch_model (
    // Clock
    input wire logic aclk,
    // Parallel panel bus
    input wire logic [23:0] pixel_data_line,
    input wire logic pixel_de_out,
    input wire logic pixel_clk_out,
    // Colour bits the panel keeps
    input wire logic [23:0] keep_mask,
    output logic [23:0] seen_word,
    // Touch controller
    input wire logic touch_reset_n,
    input wire logic touch_request,
    output logic touch_event_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_last;
    logic [3:0] hold;

    // ==========================================================
    // Panel capture on the rising pixel clock while enabled
    // low colour bits ignored
    always_ff @(posedge aclk) begin
        clk_last <= pixel_clk_out;
        if (pixel_clk_out && !clk_last && pixel_de_out) begin
            seen_word <= pixel_data_line & keep_mask;
        end
    end

    // ==========================================================
    // Touch interrupt pulse, silent while held in reset
    // event line, reset low
    always_ff @(posedge aclk) begin
        if (!touch_reset_n) begin
            hold <= 4'h0;
        end else if (touch_request) begin
            hold <= 4'hf;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end
    end
    assign touch_event_in = (hold != 4'h0);
endmodule

// ---- test/test_rgb_pixel_out.sv ----
// Self-checking bench for the parallel RGB pixel output stage
module test_rgb_pixel_out;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    pixel_out_pkg::pixel_type pixel_in = 24'h0;
    logic pixel_active_in = 0, pixel_clk_in = 0, pclk_run = 0, touch_request = 0;
    logic [23:0] keep_mask = 24'hffffff;
    logic awready, wready, bvalid, arready, rvalid, pixel_de_out, pixel_clk_out, serial_valid_out;
    logic backlight_duty_out, backlight_supply_on, panel_supply_on, touch_reset_n, touch_event_in, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [23:0] pixel_data_line, serial_pixel_out, seen_word, pix;
    int err_total = 0;
    int num_checks = 0;
    int hi, n;
    int duties[3] = '{0, 128, 255};

    // ==========================================================
    // Clocks; the link clock runs only within frames
    always #4 aclk = ~aclk;
    always #62.5 pixel_clk_in <= pclk_run ? ~pixel_clk_in : 1'b0;

    rgb_pixel_out uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pixel_in(pixel_in), .pixel_active_in(pixel_active_in),
        .pixel_clk_in(pixel_clk_in), .pixel_data_line(pixel_data_line), .pixel_de_out(pixel_de_out),
        .pixel_clk_out(pixel_clk_out), .serial_pixel_out(serial_pixel_out), .serial_valid_out(serial_valid_out),
        .backlight_duty_out(backlight_duty_out), .backlight_supply_on(backlight_supply_on),
        .panel_supply_on(panel_supply_on), .touch_reset_n(touch_reset_n), .touch_event_in(touch_event_in),
        .irq(irq));

    panel_touch_model panel (.aclk(aclk), .pixel_data_line(pixel_data_line), .pixel_de_out(pixel_de_out),
        .pixel_clk_out(pixel_clk_out), .keep_mask(keep_mask), .seen_word(seen_word),
        .touch_reset_n(touch_reset_n), .touch_request(touch_request), .touch_event_in(touch_event_in));

    // ==========================================================
    // Comparison, waits and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        num_checks++;
        if (seen !== expected) begin
            err_total++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // AXI4-Lite master cycles, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done, b_done;
        aw_done = 0;
        w_done = 0;
        b_done = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!b_done) begin
            @(posedge aclk);
            if (bvalid === 1'b1) begin
                b_done = 1;
                r = bresp;
            end
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1;
                awvalid <= 0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1;
                wvalid <= 0;
            end
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_done, r_done;
        ar_done = 0;
        r_done = 0;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (!r_done) begin
            @(posedge aclk);
            if (rvalid === 1'b1) begin
                r_done = 1;
                d = rdata;
                r = rresp;
            end
            if (!ar_done && arready === 1'b1) begin
                ar_done = 1;
                arvalid <= 0;
            end
        end
    endtask

    task automatic pulse_touch;
        touch_request <= 1;
        tick(1);
        touch_request <= 0;
        tick(20);
    endtask

    // Expected bus word for each colour format
    function automatic logic [23:0] pack_exp(input int f, input logic [23:0] p);
        case (f)
            1: return {8'h00, p[23:19], p[15:10], p[7:3]};
            2: return {6'h00, p[23:18], p[15:10], p[7:2]};
            3: return p & 24'hf8fcf8;
            4: return p & 24'hfcfcfc;
            default: return p;
        endcase
    endfunction

    // ==========================================================
    // Watchdog
    initial begin
        #500000;
        err_total++;
        tally_and_finish;
    end

    // ==========================================================
    // Test sequence
    initial begin
        tick(20);
        aresetn <= 1;
        tick(2);
        check(touch_reset_n, 0);
        for (int a = 0; a <= 16; a += 4) begin
            axi_read(8'(a), rd, resp);
            check(rd, 0);
        end
        axi_read(8'h14, rd, resp);
        check({rd[29:0], resp}, {30'h0, pixel_out_pkg::RESP_SLVERR});
        axi_write(8'h14, 32'hff, resp);
        check(resp, pixel_out_pkg::RESP_SLVERR);
        // Each side-band control alone
        for (int i = 4; i < 7; i++) begin
            axi_write(pixel_out_pkg::CTRL_OFFSET, 32'h1 << i, resp);
            tick(2);
            check(backlight_supply_on, i == 4);
            check(panel_supply_on, i == 5);
            check(touch_reset_n, i == 6);
        end
        // Touch event raised, masked, cleared
        axi_write(pixel_out_pkg::MASK_OFFSET, 32'h1, resp);
        pulse_touch;
        check(irq, 1);
        axi_write(pixel_out_pkg::STATUS_OFFSET, 32'h1, resp);
        tick(2);
        check(irq, 0);
        axi_write(pixel_out_pkg::MASK_OFFSET, 32'h0, resp);
        pulse_touch;
        axi_read(pixel_out_pkg::STATUS_OFFSET, rd, resp);
        check(irq, 0);
        check(rd, 1);
        axi_write(pixel_out_pkg::STATUS_OFFSET, 32'h1, resp);
        axi_write(pixel_out_pkg::CTRL_OFFSET, 32'h0, resp);
        pulse_touch;
        axi_read(pixel_out_pkg::STATUS_OFFSET, rd, resp);
        check(rd, 0);
        // Every colour format over the panel bus
        pclk_run <= 1;
        pixel_active_in <= 1;
        for (int f = 0; f < 6; f++) begin
            pix = 24'h9b6dc7 ^ {8'(f), 8'(f), 8'(f)};
            keep_mask <= (f == 3) ? 24'hf8fcf8 : (f == 4) ? 24'hfcfcfc : 24'hffffff;
            axi_write(pixel_out_pkg::CTRL_OFFSET, 32'(f), resp);
            pixel_in <= pix;
            tick(60);
            check(pixel_data_line, pack_exp(f, pix));
            check(seen_word, pack_exp(f, pix) & keep_mask);
            check(pixel_de_out, 1);
        end
        pixel_active_in <= 0;
        tick(60);
        axi_read(pixel_out_pkg::STATUS_OFFSET, rd, resp);
        check(pixel_de_out, 0);
        check(rd, 2);
        // Serial route carries the stream instead of the parallel bus
        pixel_active_in <= 1;
        axi_write(pixel_out_pkg::CTRL_OFFSET, 32'h8, resp);
        pix = 24'h3c5a96;
        pixel_in <= pix;
        tick(40);
        check(pixel_de_out, 0);
        n = 0;
        while (serial_valid_out !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        check(serial_valid_out, 1);
        check(serial_pixel_out, pix);
        pclk_run <= 0;
        // Backlight duty over one full period of 256 steps
        for (int i = 0; i < 3; i++) begin
            axi_write(pixel_out_pkg::DUTY_OFFSET, 32'(duties[i]), resp);
            tick(200);
            hi = 0;
            repeat (12800) begin
                @(posedge aclk);
                hi += (backlight_duty_out === 1'b1);
            end
            check(hi, duties[i] * 50);
        end
        tally_and_finish;
    end
endmodule
